// File: hw/efap_bank_mem.sv
// double-bank byte storage of one endpoint slot
`timescale 1ns/100ps
`include "efap_regs.svh"
module efap_bank_mem (
  input  wire logic        i_clk,    // core clock
  input  wire logic        i_ce,     // clock enable
  input  wire logic        i_we_lo,  // write byte at waddr
  input  wire logic        i_we_hi,  // write byte at waddr+1
  input  wire logic        i_wbank,  // bank written
  input  wire logic [4:0]  i_waddr,  // first byte written
  input  wire logic [15:0] i_wdata,  // low lane first
  input  wire logic        i_rbank,  // bank read
  input  wire logic [4:0]  i_raddr,  // first byte read
  output logic      [15:0] o_rdata   // {byte raddr+1, byte raddr}
);
  logic [7:0] mem_q [2][`EFAP_DEPTH];  // payload bytes, no reset needed
  logic [4:0] hi_addr;                 // second byte of a word
  logic [4:0] rhi_addr;                // second byte read

  assign hi_addr  = i_waddr + 5'h01;
  assign rhi_addr = i_raddr + 5'h01;

  // payload write, low lane is the earlier byte
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we_lo) begin
        mem_q[i_wbank][i_waddr] <= i_wdata[7:0];
      end
      if (i_we_hi) begin
        mem_q[i_wbank][hi_addr] <= i_wdata[15:8];
      end
    end
  end

  // asynchronous read of two neighbouring bytes
  assign o_rdata = {mem_q[i_rbank][rhi_addr], mem_q[i_rbank][i_raddr]};
endmodule

// File: hw/efap_pkg.sv
// types shared by the endpoint fifo access port
package efap_pkg;
  // slot number: bit 1 endpoint, bit 0 direction (1 = in)
  typedef logic [1:0] efap_slot_t;

  // serial engine request toward the fifos
  typedef struct packed {
    efap_slot_t  slot;   // slot the engine works on
    logic        wr;     // out: one received byte
    logic [7:0]  wdata;  // out: received byte
    logic        rd;     // in: fetch next byte to send
    logic        done;   // out: packet acked; in: packet sent
  } efap_ereq_t;

  // answer to the serial engine, all registered
  typedef struct packed {
    logic        ready;  // out: room in bank; in: packet waiting
    logic [5:0]  len;    // in: length of packet waiting
    logic [7:0]  rdata;  // in: byte fetched by rd
  } efap_eresp_t;
endpackage

// File: hw/efap_regs.svh
// register map, field positions, reset values and timing counts of the endpoint fifo access port
`ifndef EFAP_REGS_SVH
`define EFAP_REGS_SVH
// register byte offsets
`define EFAP_OFS_MPS        8'h04
`define EFAP_OFS_PBC        8'h1c
`define EFAP_OFS_FILL       8'h1e
`define EFAP_OFS_DATA       8'h20
`define EFAP_OFS_CTRL       8'h28
`define EFAP_OFS_INDEX      8'h2c
// control function command bits
`define EFAP_CTRL_VAL_BIT   3
`define EFAP_CTRL_CLR_BIT   4
// fifo size field msb in the packet size register
`define EFAP_FSZ_MSB        10
// reset values
`define EFAP_PBC_RST        16'h0000
`define EFAP_MPS_RST        11'h000
`define EFAP_RDATA_RST      16'h0000
// storage shape: bytes per buffer, slots (endpoint and direction)
`define EFAP_DEPTH          6'h20
`define EFAP_SLOTS          4
// host-side settle times, kept for the bench
`define EFAP_CLK_PS         4000
`define EFAP_T_IDX_RD_NS    190
`define EFAP_T_IDX_WR_NS    100
`define EFAP_T_FILL_NS      200
`define EFAP_CYC_IDX_RD     ((`EFAP_T_IDX_RD_NS * 1000 + `EFAP_CLK_PS - 1) / `EFAP_CLK_PS)
`define EFAP_CYC_IDX_WR     ((`EFAP_T_IDX_WR_NS * 1000 + `EFAP_CLK_PS - 1) / `EFAP_CLK_PS)
`define EFAP_CYC_FILL       ((`EFAP_T_FILL_NS * 1000 + `EFAP_CLK_PS - 1) / `EFAP_CLK_PS)
`endif

// File: hw/efap_top.sv
// endpoint fifo access port: data port, packet byte count and fill status
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "efap_regs.svh"
module efap_top (
  input  wire logic                I_REF_CLK,      // 250 mhz core clock
  input  wire logic                I_RST_B,        // async reset, active low
  input  wire logic                I_CE,           // clock enable, freezes all state
  input  wire logic                I_USB_BUS_RST,  // usb bus reset seen, one cycle
  input  wire logic [7:0]          I_ADDR,         // register byte address
  input  wire logic [15:0]         I_WDATA,        // register write data
  input  wire logic                I_WR,           // write strobe
  input  wire logic                I_RD,           // read strobe
  input  wire logic                I_BYTE_MODE,    // 1 = 8-bit access, 0 = 16-bit
  input  wire efap_pkg::efap_ereq_t I_SIE_REQ,     // serial engine request
  output logic      [15:0]         O_RDATA,        // read data, cycle after strobe
  output efap_pkg::efap_eresp_t    O_SIE_RESP      // serial engine answer
);
  localparam int NS = `EFAP_SLOTS;

  // register state
  efap_pkg::efap_slot_t idx_q;           // endpoint index
  logic [10:0]          mps_q  [NS];     // max_packet_limit per slot
  logic [15:0]          pbc_q  [NS];     // packet_byte_count_value per slot
  // buffer state
  logic [1:0]           full_q [NS];     // bank holds a packet
  logic [5:0]           len_q  [NS][2];  // bytes in each full bank
  logic                 hb_q   [NS];     // bank the host side works on
  logic                 eb_q   [NS];     // bank the engine side works on
  logic [5:0]           hp_q   [NS];     // host byte pointer
  logic [5:0]           ep_q   [NS];     // engine byte pointer
  // outputs
  logic [15:0]          rdata_q;         // register read data
  efap_pkg::efap_eresp_t resp_q;         // engine answer

  // memory port wiring per slot
  logic                 we_lo  [NS];
  logic                 we_hi  [NS];
  logic                 wbank  [NS];
  logic [4:0]           waddr  [NS];
  logic [15:0]          wdata  [NS];
  logic                 rbank  [NS];
  logic [4:0]           raddr  [NS];
  logic [15:0]          mrd    [NS];

  // host decode
  logic                 h_dwr;   // data port write accepted
  logic                 h_drd;   // data port read accepted
  logic                 h_val;   // force validate accepted
  logic                 h_clr;   // force clear requested
  logic                 h_mps;   // packet size write
  logic                 h_pbc;   // byte count write
  logic                 h_last;  // this access completes the buffer
  logic                 h_short; // completion came from a short count
  logic [1:0]           h_step;  // bytes moved by this access
  logic [5:0]           h_lim;   // effective packet limit
  logic [5:0]           h_room;  // bytes left to limit or to packet end
  logic [5:0]           h_next;  // host pointer after access
  logic [15:0]          h_word;  // data port read word
  // engine decode
  efap_pkg::efap_slot_t es;      // engine slot
  logic                 e_owr;   // out byte stored
  logic                 e_ack;   // out packet committed
  logic                 e_ird;   // in byte fetched
  logic                 e_sent;  // in packet released

  // slot direction: odd slots are in endpoints
  function automatic logic is_in(input efap_pkg::efap_slot_t s);
    return s[0];
  endfunction

  // slots of endpoint 0 are the control endpoint
  function automatic logic is_ctrl(input efap_pkg::efap_slot_t s);
    return ~s[1];
  endfunction

  // packet limit: size field capped to storage, cut by a smaller count
  function automatic logic [5:0] eff_limit(input logic [10:0] mps, input logic [15:0] pbc);
    logic [10:0] m;
    m = (mps > {5'h00, `EFAP_DEPTH}) ? {5'h00, `EFAP_DEPTH} : mps;
    if (m == 11'h000) begin
      m = 11'h001;  // a zero size would validate on every write
    end
    if ((pbc != 16'h0000) && (pbc < {5'h00, m})) begin
      m = pbc[10:0];
    end
    return m[5:0];
  endfunction

  // bytes moved: one on a byte access or when a single byte remains
  function automatic logic [1:0] step_of(input logic byte_mode, input logic [5:0] room);
    return (byte_mode || (room == 6'h01)) ? 2'h1 : 2'h2;
  endfunction

  // host access decode, always against the current index
  always_comb begin
    h_lim   = eff_limit(mps_q[idx_q], pbc_q[idx_q]);
    h_room  = is_in(idx_q) ? (h_lim - hp_q[idx_q]) : (len_q[idx_q][hb_q[idx_q]] - hp_q[idx_q]);
    h_step  = step_of(I_BYTE_MODE, h_room);
    h_next  = hp_q[idx_q] + {4'h0, h_step};
    h_last  = ({4'h0, h_step} >= h_room);
    // writes to a full bank are dropped; the host must watch fill status
    h_dwr   = I_WR && (I_ADDR == `EFAP_OFS_DATA) && is_in(idx_q) && !full_q[idx_q][hb_q[idx_q]];
    h_drd   = I_RD && (I_ADDR == `EFAP_OFS_DATA) && !is_in(idx_q) && full_q[idx_q][hb_q[idx_q]];
    h_val   = I_WR && (I_ADDR == `EFAP_OFS_CTRL) && I_WDATA[`EFAP_CTRL_VAL_BIT] && is_in(idx_q)
              && !full_q[idx_q][hb_q[idx_q]];
    h_clr   = I_WR && (I_ADDR == `EFAP_OFS_CTRL) && I_WDATA[`EFAP_CTRL_CLR_BIT];
    h_mps   = I_WR && (I_ADDR == `EFAP_OFS_MPS);
    h_pbc   = I_WR && (I_ADDR == `EFAP_OFS_PBC);
    // short completion: count below size field, only on data port path
    h_short = h_dwr && h_last && (pbc_q[idx_q] != 16'h0000)
              && (pbc_q[idx_q] < {5'h00, mps_q[idx_q]});
    // odd tail byte of a word read sits on the low lane
    h_word  = (h_step == 2'h1) ? {8'h00, mrd[idx_q][7:0]} : mrd[idx_q];
  end

  // engine decode; each event refused unless the bank is in the right state
  always_comb begin
    es     = I_SIE_REQ.slot;
    e_owr  = I_SIE_REQ.wr && !is_in(es) && !full_q[es][eb_q[es]] && (ep_q[es] < `EFAP_DEPTH);
    e_ack  = I_SIE_REQ.done && !is_in(es) && !full_q[es][eb_q[es]];
    e_ird  = I_SIE_REQ.rd && is_in(es) && full_q[es][eb_q[es]] && (ep_q[es] < len_q[es][eb_q[es]]);
    e_sent = I_SIE_REQ.done && is_in(es) && full_q[es][eb_q[es]];
  end

  // memory port steering: in slots take host writes, out slots engine writes
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      if (is_in(efap_pkg::efap_slot_t'(s))) begin
        we_lo[s] = h_dwr && (idx_q == efap_pkg::efap_slot_t'(s));
        we_hi[s] = we_lo[s] && (h_step == 2'h2);
        wbank[s] = hb_q[s];
        waddr[s] = hp_q[s][4:0];
        wdata[s] = I_WDATA;
        rbank[s] = eb_q[s];
        raddr[s] = ep_q[s][4:0];
      end else begin
        we_lo[s] = e_owr && (es == efap_pkg::efap_slot_t'(s));
        we_hi[s] = 1'b0;
        wbank[s] = eb_q[s];
        waddr[s] = ep_q[s][4:0];
        wdata[s] = {8'h00, I_SIE_REQ.wdata};
        rbank[s] = hb_q[s];
        raddr[s] = hp_q[s][4:0];
      end
    end
  end

  // one storage block per slot
  for (genvar g = 0; g < NS; g++) begin : g_slot
    efap_bank_mem u_mem (
      .i_clk   (I_REF_CLK),
      .i_ce    (I_CE),
      .i_we_lo (we_lo[g]),
      .i_we_hi (we_hi[g]),
      .i_wbank (wbank[g]),
      .i_waddr (waddr[g]),
      .i_wdata (wdata[g]),
      .i_rbank (rbank[g]),
      .i_raddr (raddr[g]),
      .o_rdata (mrd[g])
    );
  end

  // endpoint index; takes effect for the very next access
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      idx_q <= 2'h0;
    end else if (I_CE) begin
      if (I_WR && (I_ADDR == `EFAP_OFS_INDEX)) begin
        idx_q <= I_WDATA[1:0];
      end
    end
  end

  // packet size and packet byte count registers
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int s = 0; s < NS; s++) begin
        mps_q[s] <= `EFAP_MPS_RST;
        pbc_q[s] <= `EFAP_PBC_RST;
      end
    end else if (I_CE) begin
      if (I_USB_BUS_RST) begin
        // bus reset outranks any host or engine update
        for (int s = 0; s < NS; s++) begin
          mps_q[s] <= `EFAP_MPS_RST;
          pbc_q[s] <= `EFAP_PBC_RST;
        end
      end else begin
        if (h_mps) begin
          mps_q[idx_q] <= I_WDATA[`EFAP_FSZ_MSB:0];
          pbc_q[idx_q] <= {5'h00, I_WDATA[`EFAP_FSZ_MSB:0]};
        end else if (h_pbc) begin
          pbc_q[idx_q] <= I_WDATA;
        end else if (h_short) begin
          // short packet done: later packets run at full size again
          pbc_q[idx_q] <= {5'h00, mps_q[idx_q]};
        end
        // engine ack lands last so a fresh count is never lost
        if (e_ack) begin
          pbc_q[es] <= {10'h000, ep_q[es]};
        end
      end
    end
  end

  // buffer banks, pointers and fill flags of every slot
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int s = 0; s < NS; s++) begin
        full_q[s]   <= 2'h0;
        len_q[s][0] <= 6'h00;
        len_q[s][1] <= 6'h00;
        hb_q[s]     <= 1'b0;
        eb_q[s]     <= 1'b0;
        hp_q[s]     <= 6'h00;
        ep_q[s]     <= 6'h00;
      end
    end else if (I_CE) begin
      for (int s = 0; s < NS; s++) begin
        // engine side goes first so a same-cycle host update wins
        if (es == efap_pkg::efap_slot_t'(s)) begin
          if (e_sent) begin
            full_q[s][eb_q[s]] <= 1'b0;  // in packet gone, bank free
            eb_q[s]            <= ~eb_q[s];
            ep_q[s]            <= 6'h00;
          end else if (e_ird) begin
            ep_q[s] <= ep_q[s] + 6'h01;
          end else if (e_ack) begin
            full_q[s][eb_q[s]] <= 1'b1;  // out packet now readable
            len_q[s][eb_q[s]]  <= ep_q[s];
            eb_q[s]            <= ~eb_q[s];
            ep_q[s]            <= 6'h00;
          end else if (e_owr) begin
            ep_q[s] <= ep_q[s] + 6'h01;
          end
        end
        // host side on the indexed slot
        if (idx_q == efap_pkg::efap_slot_t'(s)) begin
          if (h_clr) begin
            if (!is_in(idx_q)) begin
              // out: drop the packet being read, read or not
              if (full_q[s][hb_q[s]]) begin
                full_q[s][hb_q[s]] <= 1'b0;
                hb_q[s]            <= ~hb_q[s];
              end
              hp_q[s] <= 6'h00;
            end else if (hp_q[s] != 6'h00) begin
              hp_q[s] <= 6'h00;
            end else if (full_q[s][eb_q[s]] && !(e_sent && (es == idx_q))) begin
              // in: oldest validated packet; one bank per command
              full_q[s][eb_q[s]] <= 1'b0;
              eb_q[s]            <= ~eb_q[s];
              ep_q[s]            <= 6'h00;
            end
          end else if (h_drd) begin
            if (h_last) begin
              full_q[s][hb_q[s]] <= 1'b0;
              hb_q[s]            <= ~hb_q[s];
              hp_q[s]            <= 6'h00;
            end else begin
              hp_q[s] <= h_next;
            end
          end else if (h_dwr) begin
            if (h_last) begin
              full_q[s][hb_q[s]] <= 1'b1;
              len_q[s][hb_q[s]]  <= h_next;
              hb_q[s]            <= ~hb_q[s];
              hp_q[s]            <= 6'h00;
            end else begin
              hp_q[s] <= h_next;
            end
          end else if (h_val) begin
            full_q[s][hb_q[s]] <= 1'b1;
            len_q[s][hb_q[s]]  <= hp_q[s];
            hb_q[s]            <= ~hb_q[s];
            hp_q[s]            <= 6'h00;
          end
        end
      end
    end
  end

  // register read data, valid the cycle after the strobe only
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rdata_q <= `EFAP_RDATA_RST;
    end else if (I_CE) begin
      if (I_RD) begin
        case (I_ADDR)
          `EFAP_OFS_INDEX: begin
            rdata_q <= {14'h0000, idx_q};
          end
          `EFAP_OFS_MPS: begin
            rdata_q <= {5'h00, mps_q[idx_q]};
          end
          `EFAP_OFS_PBC: begin
            rdata_q <= pbc_q[idx_q];
          end
          `EFAP_OFS_FILL: begin
            // control endpoint reports no fill status, though its two banks fill as on other slots
            rdata_q <= is_ctrl(idx_q) ? 16'h0000 : {14'h0000, full_q[idx_q]};
          end
          `EFAP_OFS_DATA: begin
            rdata_q <= h_drd ? h_word : 16'h0000;
          end
          default: begin
            rdata_q <= 16'h0000;  // control bits and unmapped read zero
          end
        endcase
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  // engine answer; ready and len trail the buffer state by one cycle
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      resp_q <= '0;
    end else if (I_CE) begin
      resp_q.ready <= is_in(es) ? full_q[es][eb_q[es]] : !full_q[es][eb_q[es]];
      resp_q.len   <= len_q[es][eb_q[es]];
      if (e_ird) begin
        resp_q.rdata <= mrd[es][7:0];
      end
    end
  end

  assign O_RDATA    = rdata_q;
  assign O_SIE_RESP = resp_q;
endmodule

// File: test/efap_sie_model.sv
// serial engine stand-in: byte and packet strobes toward the fifos
`timescale 1ns/100ps
module efap_sie_model (
  input  wire logic            i_clk,  // core clock
  output efap_pkg::efap_ereq_t o_req   // engine requests
);
  initial o_req = '0;
  // one request for one edge; a gap drops strobes and scrambles the byte lane
  task automatic pulse(input logic [1:0] s, input logic w, input logic [7:0] d, input logic r,
                       input logic dn, input int gap);
    o_req <= '{slot: s, wr: w, wdata: d, rd: r, done: dn};
    @(posedge i_clk);
    if (gap > 0) begin
      o_req <= '{slot: s, wr: 1'b0, wdata: ~d, rd: 1'b0, done: 1'b0};
      repeat (gap) @(posedge i_clk);
    end
  endtask
  // received packet: bytes in order, the ack closes it
  task automatic out_pkt(input logic [1:0] s, input logic [7:0] b [$], input int gap);
    foreach (b[i]) pulse(s, 1'b1, b[i], 1'b0, 1'b0, gap);
    pulse(s, 1'b0, 8'h00, 1'b0, 1'b1, 1);
  endtask
  // send a waiting packet: fetch n bytes, then report it gone
  task automatic in_take(input logic [1:0] s, input int n, input int gap);
    repeat (n) pulse(s, 1'b0, 8'h00, 1'b1, 1'b0, gap);
    pulse(s, 1'b0, 8'h00, 1'b0, 1'b1, 1);
  endtask
  // park on a slot until ready and len follow it
  task automatic look(input logic [1:0] s);
    pulse(s, 1'b0, 8'h00, 1'b0, 1'b0, 2);
  endtask
endmodule

// File: test/efap_top_asserts.sv
// pin-level checks of the endpoint fifo access port
`timescale 1ns/100ps
`include "efap_regs.svh"
module efap_top_asserts (
  input wire logic                  I_REF_CLK,
  input wire logic                  I_RST_B,
  input wire logic                  I_CE,
  input wire logic                  I_USB_BUS_RST,
  input wire logic [7:0]            I_ADDR,
  input wire logic [15:0]           I_WDATA,
  input wire logic                  I_WR,
  input wire logic                  I_RD,
  input wire logic                  I_BYTE_MODE,
  input wire efap_pkg::efap_ereq_t  I_SIE_REQ,
  input wire logic [15:0]           O_RDATA,
  input wire efap_pkg::efap_eresp_t O_SIE_RESP
);
  logic [1:0] idx_q;  // last index written
  logic       quiet;  // no engine ack or bus reset can touch the count
  assign quiet = I_CE && !I_SIE_REQ.done && !I_USB_BUS_RST;
  // mirror of the index, so reads can be judged per slot
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      idx_q <= 2'h0;
    end else if (I_CE && I_WR && I_ADDR == `EFAP_OFS_INDEX) begin
      idx_q <= I_WDATA[1:0];
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  a_rdata_idle: assert property (I_CE && !I_RD |=> O_RDATA == 16'h0000)
    else $error("read data not zero without a read");
  a_fill_upper: assert property (I_CE && I_RD && I_ADDR == `EFAP_OFS_FILL |=> O_RDATA[15:2] == 14'h0)
    else $error("fill status upper bits set");
  a_ctrl_fill: assert property (I_CE && I_RD && I_ADDR == `EFAP_OFS_FILL && !idx_q[1] |=> O_RDATA == 16'h0)
    else $error("control endpoint fill status not zero");
  a_in_rd_zero: assert property (I_CE && I_RD && I_ADDR == `EFAP_OFS_DATA && idx_q[0] |=> O_RDATA == 16'h0)
    else $error("data read on in slot returned data");
  a_size_reload: assert property (quiet && I_WR && !I_BYTE_MODE && I_ADDR == `EFAP_OFS_MPS ##1
    quiet && I_RD && I_ADDR == `EFAP_OFS_PBC |=> O_RDATA == ($past(I_WDATA, 2) & 16'h07ff))
    else $error("byte count not reloaded from size");
  a_count_rw: assert property (quiet && I_WR && !I_BYTE_MODE && I_ADDR == `EFAP_OFS_PBC ##1
    quiet && I_RD && I_ADDR == `EFAP_OFS_PBC |=> O_RDATA == $past(I_WDATA, 2))
    else $error("byte count write not read back");
  a_bus_reset: assert property (I_CE && I_USB_BUS_RST && !I_WR && !I_SIE_REQ.done ##1
    I_CE && I_RD && I_ADDR == `EFAP_OFS_PBC && !I_SIE_REQ.done |=> O_RDATA == 16'h0)
    else $error("byte count not cleared by bus reset");
  a_eng_hold: assert property (!(I_CE && I_SIE_REQ.rd) |=> $stable(O_SIE_RESP.rdata))
    else $error("engine byte changed without a fetch");
  c_in_ready: cover property (O_SIE_RESP.ready && I_SIE_REQ.slot[0]);
  c_out_read: cover property (I_RD && I_ADDR == `EFAP_OFS_DATA && !idx_q[0]);
  c_bus_reset: cover property (I_USB_BUS_RST);
endmodule
bind efap_top efap_top_asserts u_chk (.I_REF_CLK, .I_RST_B, .I_CE, .I_USB_BUS_RST, .I_ADDR, .I_WDATA,
  .I_WR, .I_RD, .I_BYTE_MODE, .I_SIE_REQ, .O_RDATA, .O_SIE_RESP);

// File: test/efap_top_test.sv
// self-checking bench: host bus tasks, engine stand-in, queued expectations
`timescale 1ns/100ps
`include "efap_regs.svh"
module efap_top_test;
  logic                  clk = 1'b0;       // core clock
  logic                  rst_b = 1'b0;     // async reset, active low
  logic                  ce = 1'b1;        // clock enable, dropped for one write
  logic                  bus_rst = 1'b0;   // usb bus reset pulse
  logic                  wr = 1'b0;        // write strobe
  logic                  rd = 1'b0;        // read strobe
  logic                  bmode = 1'b0;     // 8-bit access when high
  logic [7:0]            addr = 8'h00;     // register address
  logic [15:0]           wdata = 16'h0000; // write data
  logic [15:0]           rdata;            // read answer
  efap_pkg::efap_ereq_t  req;              // engine requests
  efap_pkg::efap_eresp_t resp;             // engine answers
  logic [15:0]           rd_q [$];         // expected read answers
  logic [15:0]           sie_q [$];        // expected engine bytes
  logic                  rd_seen = 1'b0;   // read taken at last edge
  logic                  srd_seen = 1'b0;  // engine fetch taken at last edge
  int                    error_cnt = 0;
  int                    tests_run = 0;

  always #2 clk = ~clk;

  efap_top u_dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_USB_BUS_RST(bus_rst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_BYTE_MODE(bmode),
    .I_SIE_REQ(req), .O_RDATA(rdata), .O_SIE_RESP(resp));
  efap_sie_model u_sie (.i_clk(clk), .o_req(req));

  // verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one comparison of a settled result
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // write cycle; strobe stays up until the next task decides
  task automatic bw(input logic [7:0] a, input logic [15:0] d, input logic b);
    addr <= a;
    wdata <= d;
    bmode <= b;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // read cycle; the answer is noted for the monitor
  task automatic br(input logic [7:0] a, input logic [15:0] e, input logic b);
    rd_q.push_back(e);
    addr <= a;
    bmode <= b;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
  endtask
  // strobes down for n edges
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // engine view of a slot: {ready, len}
  task automatic look(input logic [1:0] s, input logic [6:0] e);
    idle(1);
    u_sie.look(s);
    cmp({9'h0, e}, {9'h0, resp.ready, resp.len});
  endtask
  // engine fetches of a word, low lane first
  task automatic exp_bytes(input logic [15:0] v, input int n);
    sie_q.push_back({8'h00, v[7:0]});
    if (n > 1) sie_q.push_back({8'h00, v[15:8]});
  endtask

  // monitor: oldest note against each answer
  always @(posedge clk) begin
    if (rd_seen) cmp(rd_q.pop_front(), rdata);
    if (srd_seen) cmp(sie_q.pop_front(), {8'h00, resp.rdata});
    rd_seen <= rd;
    srd_seen <= req.rd;
  end

  // main sequence
  initial begin
    logic [15:0] w [5];
    logic [7:0]  b [$];
    void'($urandom(32'h94c6));
    foreach (w[i]) w[i] = 16'($urandom);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // reset values, unmapped place
    br(`EFAP_OFS_PBC, 16'h0, 1'b0);
    br(`EFAP_OFS_FILL, 16'h0, 1'b0);
    br(`EFAP_OFS_DATA, 16'h0, 1'b0);
    br(8'h3e, 16'h0, 1'b0);
    // in slot: size reload, refused read, one full packet by words
    bw(`EFAP_OFS_INDEX, 16'h0003, 1'b0);
    idle(`EFAP_CYC_IDX_RD);
    bw(`EFAP_OFS_MPS, 16'h0004, 1'b0);
    br(`EFAP_OFS_PBC, 16'h0004, 1'b0);
    br(`EFAP_OFS_MPS, 16'h0004, 1'b0);
    br(`EFAP_OFS_INDEX, 16'h0003, 1'b0);
    br(`EFAP_OFS_DATA, 16'h0, 1'b0);
    bw(`EFAP_OFS_DATA, w[0], 1'b0);
    bw(`EFAP_OFS_DATA, w[1], 1'b0);
    look(2'h3, {1'b1, 6'd4});
    // short second packet by count: one word then one byte
    bw(`EFAP_OFS_PBC, 16'h0003, 1'b0);
    br(`EFAP_OFS_PBC, 16'h0003, 1'b0);
    bw(`EFAP_OFS_DATA, w[2], 1'b0);
    bw(`EFAP_OFS_DATA, w[3], 1'b1);
    idle(`EFAP_CYC_FILL);
    br(`EFAP_OFS_FILL, 16'h0003, 1'b0);
    exp_bytes(w[0], 2);
    exp_bytes(w[1], 2);
    idle(1);
    u_sie.in_take(2'h3, 4, 0);
    look(2'h3, {1'b1, 6'd3});
    exp_bytes(w[2], 2);
    exp_bytes(w[3], 1);
    u_sie.in_take(2'h3, 3, 2);
    br(`EFAP_OFS_PBC, 16'h0004, 1'b0);
    // one byte sent by force validate
    bw(`EFAP_OFS_DATA, w[4], 1'b1);
    bw(`EFAP_OFS_CTRL, 16'h0008, 1'b0);
    look(2'h3, {1'b1, 6'd1});
    exp_bytes(w[4], 1);
    u_sie.in_take(2'h3, 1, 0);
    idle(`EFAP_CYC_FILL);
    br(`EFAP_OFS_FILL, 16'h0, 1'b0);
    // out slot: odd packet read by words, then by bytes
    bw(`EFAP_OFS_INDEX, 16'h0002, 1'b0);
    idle(`EFAP_CYC_IDX_RD);
    b = '{w[0][7:0], w[0][15:8], w[1][7:0]};
    u_sie.out_pkt(2'h2, b, 1);
    br(`EFAP_OFS_PBC, 16'h0003, 1'b0);
    br(`EFAP_OFS_DATA, w[0], 1'b0);
    br(`EFAP_OFS_DATA, {8'h00, w[1][7:0]}, 1'b0);
    br(`EFAP_OFS_DATA, 16'h0, 1'b0);
    b = '{w[2][7:0], w[2][15:8]};
    idle(1);
    u_sie.out_pkt(2'h2, b, 0);
    br(`EFAP_OFS_DATA, {8'h00, w[2][7:0]}, 1'b1);
    br(`EFAP_OFS_DATA, {8'h00, w[2][15:8]}, 1'b1);
    br(`EFAP_OFS_DATA, 16'h0, 1'b0);
    // both banks full, then two force clears
    idle(1);
    u_sie.out_pkt(2'h2, b, 0);
    u_sie.out_pkt(2'h2, b, 0);
    idle(`EFAP_CYC_FILL);
    br(`EFAP_OFS_FILL, 16'h0003, 1'b0);
    bw(`EFAP_OFS_CTRL, 16'h0010, 1'b0);
    bw(`EFAP_OFS_CTRL, 16'h0010, 1'b0);
    br(`EFAP_OFS_FILL, 16'h0, 1'b0);
    br(`EFAP_OFS_DATA, 16'h0, 1'b0);
    // control endpoint holds a packet yet shows no fill status
    bw(`EFAP_OFS_INDEX, 16'h0001, 1'b0);
    idle(`EFAP_CYC_IDX_WR);
    bw(`EFAP_OFS_DATA, w[3], 1'b1);
    idle(`EFAP_CYC_FILL);
    br(`EFAP_OFS_FILL, 16'h0, 1'b0);
    // bus reset right after a size write
    bw(`EFAP_OFS_INDEX, 16'h0003, 1'b0);
    bw(`EFAP_OFS_MPS, 16'h0006, 1'b0);
    bus_rst <= 1'b1;
    idle(1);
    bus_rst <= 1'b0;
    br(`EFAP_OFS_PBC, 16'h0, 1'b0);
    br(`EFAP_OFS_MPS, 16'h0, 1'b0);
    // clock enable low: a count write must leave no trace
    ce <= 1'b0;
    bw(`EFAP_OFS_PBC, 16'h0005, 1'b0);
    ce <= 1'b1;
    br(`EFAP_OFS_PBC, 16'h0, 1'b0);
    idle(4);
    finish_test();
  end

  // hang guard: a run this long counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
